// file: tap_map.svh
// Notes on behaviour
// [R1] Capture-IR loads binary 01 into the two lowest instruction bits.
// [R2] Shift-IR puts the instruction shifter between TDI and TDO.
// [R3] A new instruction takes effect only at Update-IR.
// [R4] Code 111 selects the one-bit bypass register in Shift-DR.
// [R5] Code 100 captures ring levels at Capture-DR, then shifts them out.
// [R6] Code 100 Update-DR does nothing, exactly like a pause.
// [R7] The system keeps memory inputs stable around any boundary capture.
// [R8] Code 000 overrides controls, enables data drivers, selects boundary register.
// [R9] Under 000 one memory clock edge moves boundary bits onto pins.
// [R10] Code 001 captures the ID word and shifts it out.
// [R11] The instruction holds the ID code after reset and in Test-Logic-Reset.
// [R12] Code 010 forces outputs high-Z, captures ring, selects boundary register.
// [R13] Codes 011 and 110 behave exactly like bypass.
// [R14] Only code 000 drives pins from the boundary register; no preload, no internal test.
// [R15] The memory clock may run, except during ring capture.
// [R16] Instruction register is three bits, MSB written on left.
// [R17] Inputs sampled on rising test clock, TDO changes on falling edge.
// [R18] Five rising test clock edges with TMS high reach Test-Logic-Reset.
// [R19] The 32-bit ID register shifts out bit 0 first.
// [R20] The controller never loads code 101; the code loads it at Update-IR and gives it bypass.
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH
`define TAP_IR_W 3
`define TAP_ID_W 32
`define TAP_BSR_LEN 78
`define TAP_CODE_EXTEST 3'h0
`define TAP_CODE_IDCODE 3'h1
`define TAP_CODE_SAMPLEZ 3'h2
`define TAP_CODE_RSVD_A 3'h3
`define TAP_CODE_SAMPLE 3'h4
`define TAP_CODE_PRIVATE 3'h5
`define TAP_CODE_RSVD_B 3'h6
`define TAP_CODE_BYPASS 3'h7
`define TAP_IR_CAPTURE 3'h1
`define TAP_TLR_ONES 3'h5
`endif

// file: tap_pkg.sv
package tap_pkg;
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } tap_state_t;
    typedef enum logic [1:0] {
        PATH_BYPASS, PATH_ID, PATH_BSR
    } path_t;
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } pins_t;
    typedef struct packed {
        logic ctrl_override;
        logic dq_drive_en;
        logic outputs_highz;
    } mode_t;
endpackage : tap_pkg

// file: tap_sync.sv
`timescale 1ns/10ps
module tap_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] out_ff;

    // three stages; first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s1_ff <= RST;
            s2_ff <= RST;
            s3_ff <= RST;
        end else begin
            s1_ff <= i_async;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // a bit moves only once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    out_ff[g] <= RST[g];
                end else if (s2_ff[g] == s3_ff[g]) begin
                    out_ff[g] <= s2_ff[g];
                end
            end
        end
    endgenerate

    assign o_sync = out_ff;
endmodule : tap_sync

// file: tap_instruction_decoder.sv
`timescale 1ns/10ps
`include "tap_map.svh"
module tap_instruction_decoder #(
    parameter int BSR_LEN = `TAP_BSR_LEN,
    // identification word; value is arbitrary
    parameter logic [`TAP_ID_W-1:0] ID_CODE = 32'h0000_0001
) (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_TCK,
    input wire logic I_TMS,
    input wire logic I_TDI,
    input wire logic [BSR_LEN-1:0] I_RING_LEVELS,
    output logic O_TDO,
    output logic O_TDO_OE,
    output logic O_CTRL_OVERRIDE,
    output logic O_DQ_DRIVE_EN,
    output logic O_OUTPUTS_HIGHZ,
    output logic [BSR_LEN-1:0] O_BSR_DRIVE_DATA
);
    tap_pkg::pins_t pins;
    tap_pkg::pins_t pins_raw;
    tap_pkg::tap_state_t state_ff;
    tap_pkg::tap_state_t nxt_state;
    tap_pkg::mode_t mode_ff;
    tap_pkg::mode_t nxt_mode;
    tap_pkg::path_t path;
    logic [BSR_LEN-1:0] ring;
    logic tck_prev_ff;
    logic tck_rise;
    logic tck_fall;
    logic [`TAP_IR_W-1:0] ir_ff;
    logic [`TAP_IR_W-1:0] ir_shift_ff;
    logic [`TAP_ID_W-1:0] id_ff;
    logic [BSR_LEN-1:0] bsr_ff;
    logic byp_ff;
    logic tdo_ff;
    logic tdo_oe_ff;
    logic [2:0] ones_cnt_ff;

    // which data register an instruction selects; 101 gets bypass too
    function automatic tap_pkg::path_t path_of(
        input logic [`TAP_IR_W-1:0] code
    );
        unique case (code)
            `TAP_CODE_EXTEST, `TAP_CODE_SAMPLEZ,
            `TAP_CODE_SAMPLE: path_of = tap_pkg::PATH_BSR; // [R8] [R12] [R5]
            `TAP_CODE_IDCODE: path_of = tap_pkg::PATH_ID; // [R10]
            default: path_of = tap_pkg::PATH_BYPASS; // [R4] [R13]
        endcase
    endfunction : path_of

    assign pins_raw = '{tck: I_TCK, tms: I_TMS, tdi: I_TDI};

    // pins idle high through their pull-ups
    tap_sync #(.W(3), .RST(3'h7)) u_pin_sync (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_async(pins_raw),
        .o_sync(pins)
    );

    // ring levels come from the memory clock domain
    tap_sync #(.W(BSR_LEN), .RST('0)) u_ring_sync (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_async(I_RING_LEVELS),
        .o_sync(ring)
    );

    // test clock edges, found on the settled copy
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            tck_prev_ff <= 1'b1;
        end else begin
            tck_prev_ff <= pins.tck;
        end
    end
    assign tck_rise = pins.tck & ~tck_prev_ff; // [R17]
    assign tck_fall = ~pins.tck & tck_prev_ff; // [R17]
    assign path = path_of(ir_ff);

    // controller state walk; all ones always ends in reset
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            tap_pkg::TLR: nxt_state = pins.tms ? tap_pkg::TLR : tap_pkg::RTI;
            tap_pkg::RTI: nxt_state = pins.tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
            tap_pkg::SEL_DR: nxt_state = pins.tms ? tap_pkg::SEL_IR
                                                  : tap_pkg::CAP_DR;
            tap_pkg::CAP_DR: nxt_state = pins.tms ? tap_pkg::EX1_DR
                                                  : tap_pkg::SHF_DR;
            tap_pkg::SHF_DR: nxt_state = pins.tms ? tap_pkg::EX1_DR
                                                  : tap_pkg::SHF_DR;
            tap_pkg::EX1_DR: nxt_state = pins.tms ? tap_pkg::UPD_DR
                                                  : tap_pkg::PAU_DR;
            tap_pkg::PAU_DR: nxt_state = pins.tms ? tap_pkg::EX2_DR
                                                  : tap_pkg::PAU_DR;
            tap_pkg::EX2_DR: nxt_state = pins.tms ? tap_pkg::UPD_DR
                                                  : tap_pkg::SHF_DR;
            tap_pkg::UPD_DR: nxt_state = pins.tms ? tap_pkg::SEL_DR
                                                  : tap_pkg::RTI;
            tap_pkg::SEL_IR: nxt_state = pins.tms ? tap_pkg::TLR
                                                  : tap_pkg::CAP_IR;
            tap_pkg::CAP_IR: nxt_state = pins.tms ? tap_pkg::EX1_IR
                                                  : tap_pkg::SHF_IR;
            tap_pkg::SHF_IR: nxt_state = pins.tms ? tap_pkg::EX1_IR
                                                  : tap_pkg::SHF_IR;
            tap_pkg::EX1_IR: nxt_state = pins.tms ? tap_pkg::UPD_IR
                                                  : tap_pkg::PAU_IR;
            tap_pkg::PAU_IR: nxt_state = pins.tms ? tap_pkg::EX2_IR
                                                  : tap_pkg::PAU_IR;
            tap_pkg::EX2_IR: nxt_state = pins.tms ? tap_pkg::UPD_IR
                                                  : tap_pkg::SHF_IR;
            tap_pkg::UPD_IR: nxt_state = pins.tms ? tap_pkg::SEL_DR
                                                  : tap_pkg::RTI;
        endcase
    end

    // state moves on the rising test clock only
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            state_ff <= tap_pkg::TLR;
        end else if (tck_rise) begin
            state_ff <= nxt_state; // [R18]
        end
    end

    // instruction shifter: capture pattern, then serial load
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            ir_shift_ff <= `TAP_IR_CAPTURE;
        end else if (tck_rise) begin
            if (state_ff == tap_pkg::CAP_IR) begin
                ir_shift_ff <= `TAP_IR_CAPTURE; // [R1]
            end else if (state_ff == tap_pkg::SHF_IR) begin
                ir_shift_ff <= {pins.tdi, ir_shift_ff[`TAP_IR_W-1:1]}; // [R2]
            end
        end
    end

    // live instruction changes only at update or in reset state
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            ir_ff <= `TAP_CODE_IDCODE; // [R11]
        end else if (state_ff == tap_pkg::TLR) begin
            ir_ff <= `TAP_CODE_IDCODE; // [R11]
        end else if (tck_fall && state_ff == tap_pkg::UPD_IR) begin
            ir_ff <= ir_shift_ff; // [R3] [R16]
        end
    end

    // data registers; update-dr has no preload stage at all
    always_ff @(posedge I_CLK) begin // [R6]
        if (I_SRST) begin
            byp_ff <= 1'b0;
            id_ff <= '0;
            bsr_ff <= '0;
        end else if (tck_rise && state_ff == tap_pkg::CAP_DR) begin
            byp_ff <= 1'b0;
            if (path == tap_pkg::PATH_ID) begin
                id_ff <= ID_CODE; // [R10]
            end
            if (path == tap_pkg::PATH_BSR) begin
                bsr_ff <= ring; // [R5] [R12] [R14]
            end
        end else if (tck_rise && state_ff == tap_pkg::SHF_DR) begin
            unique case (path)
                tap_pkg::PATH_BYPASS: byp_ff <= pins.tdi; // [R4] [R13]
                tap_pkg::PATH_ID: id_ff <= {pins.tdi, id_ff[`TAP_ID_W-1:1]};
                tap_pkg::PATH_BSR: bsr_ff <= {pins.tdi, bsr_ff[BSR_LEN-1:1]};
            endcase
        end
    end

    // output launches on falling edge, lsb first
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            tdo_ff <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_ff <= (state_ff == tap_pkg::SHF_IR) ||
                         (state_ff == tap_pkg::SHF_DR); // [R17]
            if (state_ff == tap_pkg::SHF_IR) begin
                tdo_ff <= ir_shift_ff[0]; // [R2]
            end else if (state_ff == tap_pkg::SHF_DR) begin
                unique case (path)
                    tap_pkg::PATH_BYPASS: tdo_ff <= byp_ff; // [R4]
                    tap_pkg::PATH_ID: tdo_ff <= id_ff[0]; // [R19]
                    tap_pkg::PATH_BSR: tdo_ff <= bsr_ff[0];
                endcase
            end
        end
    end

    // pin modes follow the live instruction
    always_comb begin
        nxt_mode.ctrl_override = (ir_ff == `TAP_CODE_EXTEST); // [R8]
        nxt_mode.dq_drive_en = (ir_ff == `TAP_CODE_EXTEST); // [R8]
        nxt_mode.outputs_highz = (ir_ff == `TAP_CODE_SAMPLEZ); // [R12]
    end

    // registered so the memory never sees a decode glitch
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            mode_ff <= '0;
            O_BSR_DRIVE_DATA <= '0;
        end else begin
            mode_ff <= nxt_mode;
            O_BSR_DRIVE_DATA <= bsr_ff; // [R9]
        end
    end

    assign O_TDO = tdo_ff;
    assign O_TDO_OE = tdo_oe_ff;
    assign O_CTRL_OVERRIDE = mode_ff.ctrl_override;
    assign O_DQ_DRIVE_EN = mode_ff.dq_drive_en;
    assign O_OUTPUTS_HIGHZ = mode_ff.outputs_highz;

    // helper: consecutive tms-high rising edges, saturating
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            ones_cnt_ff <= 3'h0;
        end else if (tck_rise) begin
            if (!pins.tms) begin
                ones_cnt_ff <= 3'h0;
            end else if (ones_cnt_ff != `TAP_TLR_ONES) begin
                ones_cnt_ff <= ones_cnt_ff + 3'h1;
            end
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);

    sequence seq_ir_update;
        tck_fall && state_ff == tap_pkg::UPD_IR;
    endsequence
    sequence seq_dr_capture;
        tck_rise && state_ff == tap_pkg::CAP_DR;
    endsequence
    sequence seq_dr_shift_out;
        tck_fall && state_ff == tap_pkg::SHF_DR;
    endsequence

    a_capture_ir_pattern: // [R1]
    assert property (tck_rise && state_ff == tap_pkg::CAP_IR
                     |=> ir_shift_ff[1:0] == 2'h1)
        else $error("capture-ir pattern wrong");

    a_ir_shift_path: // [R2]
    assert property (tck_rise && state_ff == tap_pkg::SHF_IR
                     |=> ir_shift_ff == {$past(pins.tdi),
                                         $past(ir_shift_ff[2:1])})
        else $error("instruction shift wrong");

    a_ir_update_only: // [R3]
    assert property (ir_ff != $past(ir_ff) |->
                     $past(state_ff) == tap_pkg::TLR ||
                     $past(tck_fall && state_ff == tap_pkg::UPD_IR))
        else $error("instruction changed outside update");

    a_ir_update_load: // [R3]
    assert property (seq_ir_update ##0 state_ff != tap_pkg::TLR
                     |=> ir_ff == $past(ir_shift_ff))
        else $error("update-ir did not load");

    a_ir_reset_idcode: // [R11]
    assert property (state_ff == tap_pkg::TLR
                     |=> ir_ff == `TAP_CODE_IDCODE)
        else $error("reset state lost id instruction");

    a_bypass_out: // [R4] [R13]
    assert property (seq_dr_shift_out ##0 path == tap_pkg::PATH_BYPASS
                     |=> O_TDO == $past(byp_ff))
        else $error("bypass bit not on tdo");

    a_ring_capture: // [R5] [R12]
    assert property (seq_dr_capture ##0 path == tap_pkg::PATH_BSR
                     |=> bsr_ff == $past(ring))
        else $error("ring not captured");

    a_no_preload: // [R6] [R14]
    assert property (bsr_ff != $past(bsr_ff) |->
                     $past(state_ff) == tap_pkg::CAP_DR ||
                     $past(state_ff) == tap_pkg::SHF_DR)
        else $error("boundary register changed outside capture/shift");

    a_extest_drive: // [R8]
    assert property (ir_ff == `TAP_CODE_EXTEST
                     |=> O_CTRL_OVERRIDE && O_DQ_DRIVE_EN && !O_OUTPUTS_HIGHZ)
        else $error("extest drive mode missing");

    a_drive_data: // [R9]
    assert property (1'b1 |=> O_BSR_DRIVE_DATA == $past(bsr_ff))
        else $error("drive data not boundary register");

    a_id_capture: // [R10]
    assert property (seq_dr_capture ##0 path == tap_pkg::PATH_ID
                     |=> id_ff == ID_CODE)
        else $error("id word not captured");

    a_id_lsb_first: // [R19]
    assert property (seq_dr_shift_out ##0 path == tap_pkg::PATH_ID
                     |=> O_TDO == $past(id_ff[0]))
        else $error("id not lsb first");

    a_highz_mode: // [R12]
    assert property (ir_ff == `TAP_CODE_SAMPLEZ
                     |=> O_OUTPUTS_HIGHZ && !O_DQ_DRIVE_EN)
        else $error("high-z mode missing");

    a_tdo_on_fall: // [R17]
    assert property (O_TDO != $past(O_TDO) |-> $past(tck_fall))
        else $error("tdo moved off falling edge");

    a_five_ones_reset: // [R18]
    assert property (ones_cnt_ff == `TAP_TLR_ONES |-> state_ff == tap_pkg::TLR)
        else $error("five ones did not reset");
endmodule : tap_instruction_decoder

// file: tap_scan_host.sv
`timescale 1ns/10ps
module tap_scan_host #(
    parameter int DW = 78
) (
    input wire logic i_clk,
    input wire logic i_tdo,
    input wire logic i_tdo_oe,
    output tap_pkg::pins_t o_pins,
    output logic o_obs_stb,
    output logic [DW-1:0] o_obs_word,
    output logic o_obs_oe
);
    // pins rest high like the pull-ups; test clock stands still between scans
    initial begin
        o_pins = '1;
        o_obs_stb = 1'b0;
        o_obs_word = '0;
        o_obs_oe = 1'b0;
    end

    // one test clock period: fall, 4 cycles low, rise, 4 cycles high;
    // called at a clock edge, so back-to-back calls give exactly 320 ns
    task automatic tck_cycle(input logic tms, input logic tdi,
                             output logic tdo);
        o_pins <= '{tck: 1'b0, tms: tms, tdi: tdi};
        repeat (4) @(posedge i_clk);
        o_pins.tck <= 1'b1;
        repeat (4) @(posedge i_clk);
        tdo = i_tdo; // late look: the design sees the fall 4 cycles late and moves tdo one cycle after
    endtask : tck_cycle

    // five ones reach test-logic-reset from anywhere, then park in idle
    task automatic to_idle();
        logic d;
        repeat (5) tck_cycle(1'b1, 1'b1, d);
        tck_cycle(1'b0, 1'b1, d);
    endtask : to_idle

    // idle to idle scan of n bits, lsb first, through the ir or dr path
    task automatic scan(input logic ir, input int n,
                        input logic [DW-1:0] din);
        logic d;
        logic oe;
        logic [DW-1:0] w;
        w = '0;
        oe = 1'b1;
        tck_cycle(1'b1, 1'b1, d);
        if (ir) begin
            tck_cycle(1'b1, 1'b1, d);
        end
        tck_cycle(1'b0, 1'b1, d);
        tck_cycle(1'b0, 1'b1, d);
        for (int i = 0; i < n; i++) begin
            tck_cycle(i == n - 1, din[i], d);
            w[i] = d;
            oe = oe & i_tdo_oe;
        end
        tck_cycle(1'b1, 1'b1, d);
        tck_cycle(1'b0, 1'b1, d);
        o_obs_word <= w;
        o_obs_oe <= oe;
        o_obs_stb <= 1'b1;
        @(posedge i_clk);
        o_obs_stb <= 1'b0;
    endtask : scan
endmodule : tap_scan_host

// file: tap_instruction_decoder_test.sv
`timescale 1ns/10ps
module tap_instruction_decoder_test;
    localparam int DW = 78;
    // identification word; value is arbitrary
    localparam logic [31:0] ID_WORD = 32'h1234_5679;
    typedef struct packed {
        logic [DW-1:0] val;
        logic [DW-1:0] mask;
    } note_t;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [DW-1:0] ring = '0;
    tap_pkg::pins_t pins;
    logic tdo, tdo_oe, ctrl_ovr, dq_en, highz, obs_stb, obs_oe;
    logic [DW-1:0] drive_data, obs_word;
    note_t notes[$];
    note_t nt;
    int num_errors = 0;
    int tests_run = 0;
    int seed = 32'hf6e2;

    // 25 MHz system clock
    always #20 clk = ~clk;

    tap_instruction_decoder #(.BSR_LEN(DW), .ID_CODE(ID_WORD))
        tap_instruction_decoder_i (
        .I_CLK(clk), .I_SRST(srst),
        .I_TCK(pins.tck), .I_TMS(pins.tms), .I_TDI(pins.tdi),
        .I_RING_LEVELS(ring), .O_TDO(tdo), .O_TDO_OE(tdo_oe),
        .O_CTRL_OVERRIDE(ctrl_ovr), .O_DQ_DRIVE_EN(dq_en),
        .O_OUTPUTS_HIGHZ(highz), .O_BSR_DRIVE_DATA(drive_data)
    );

    tap_scan_host #(.DW(DW)) tap_scan_host_i (
        .i_clk(clk), .i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_pins(pins),
        .o_obs_stb(obs_stb), .o_obs_word(obs_word), .o_obs_oe(obs_oe)
    );

    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] want);
        tests_run++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                     want);
        end
    endtask : check

    task automatic expect_word(input logic [DW-1:0] val,
                               input logic [DW-1:0] mask);
        notes.push_back('{val: val & mask, mask: mask});
    endtask : expect_word

    task automatic end_of_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    // each finished scan is matched against the oldest note
    always @(posedge clk) begin
        if (obs_stb === 1'b1) begin
            if (notes.size() > 0) begin
                nt = notes.pop_front();
                check(obs_word & nt.mask, nt.val);
                check(obs_oe, 1'b1);
            end else begin
                num_errors++;
                $display("unexpected at %0t: seen %h expected %h", $time,
                         obs_word, 1'b0);
            end
        end
    end

    // hang guard well above the longest run
    initial begin
        repeat (90000) @(posedge clk);
        num_errors++;
        end_of_test();
    end

    initial begin
        logic [95:0] r;
        logic [DW-1:0] d;
        int n;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        tap_scan_host_i.to_idle();
        check({ctrl_ovr, dq_en, highz}, 3'h0);
        expect_word(ID_WORD, 32'hFFFF_FFFF);
        tap_scan_host_i.scan(1'b0, 32, '0);
        // every code but the private one, each followed by a data scan
        for (int c = 0; c < 8; c++) begin
            if (c == 5) begin
                continue;
            end
            expect_word(3'h1, 3'h7);
            tap_scan_host_i.scan(1'b1, 3, DW'(3'(c)));
            check({ctrl_ovr, dq_en, highz},
                  {c == 0, c == 0, c == 2});
            r = {$random(seed), $random(seed), $random(seed)};
            d = r[DW-1:0];
            // ring value kept in r: the pin itself updates only after this step
            r = {$random(seed), $random(seed), $random(seed)};
            ring <= r[DW-1:0];
            n = DW;
            case (c)
                0, 2, 4: begin
                    expect_word(r[DW-1:0], '1);
                end
                1: begin
                    n = 32;
                    expect_word(ID_WORD, 32'hFFFF_FFFF);
                end
                default: begin
                    n = 8;
                    expect_word({d[6:0], 1'b0}, 8'hFF);
                end
            endcase
            tap_scan_host_i.scan(1'b0, n, d);
            if (c == 0) begin
                check(drive_data, d);
            end
            check({ctrl_ovr, dq_en, highz},
                  {c == 0, c == 0, c == 2});
        end
        // leave a live code via five ones, then via a mid-run reset
        for (int k = 0; k < 2; k++) begin
            expect_word(3'h1, 3'h7);
            tap_scan_host_i.scan(1'b1, 3, (k == 0) ? DW'(3'h7) : DW'(3'h2));
            check({ctrl_ovr, dq_en, highz}, {2'h0, k == 1});
            if (k == 1) begin
                srst <= 1'b1;
                repeat (4) @(posedge clk);
                srst <= 1'b0;
                repeat (4) @(posedge clk);
                check({ctrl_ovr, dq_en, highz}, 3'h0);
            end
            tap_scan_host_i.to_idle();
            check({ctrl_ovr, dq_en, highz}, 3'h0);
            expect_word(ID_WORD, 32'hFFFF_FFFF);
            tap_scan_host_i.scan(1'b0, 32, '1);
        end
        // let the last note be matched before the verdict
        for (int w = 0; w < 100 && notes.size() > 0; w++) begin
            @(posedge clk);
        end
        if (notes.size() != 0) begin
            num_errors++;
        end
        end_of_test();
    end
endmodule : tap_instruction_decoder_test
